// file: hw/pcs_device.sv
// Device end: counts rising edges on the control pin and drives switch outputs.
// Assumes the pin is asynchronous to core_clk and the host keeps its timing.
`timescale 1ns/1ps
`default_nettype none
module pcs_device #(
  parameter bit          SIX_CHANNEL = 1'b0,             // One selects six channels.
  parameter int unsigned LATCH_CYCLES = pcs_pkg::LATCH_CYC, // Latch timeout in cycles.
  parameter int unsigned OFF_CYCLES   = pcs_pkg::OFF_CYC    // Off timeout in cycles.
) (
  input  wire logic core_clk,            // Core clock, 20 MHz.
  input  wire logic resetn,              // Asynchronous reset, active low.
  pcs_link_if.dev   link,                // Control pin from the host.
  output var  logic channel_one_switch,   // Channel one switch enable.
  output var  logic channel_two_switch,   // Channel two switch enable.
  output var  logic channel_three_switch, // Channel three switch enable.
  output var  logic channel_four_switch,  // Channel four switch enable.
  output var  logic channel_five_switch,  // Channel five switch enable.
  output var  logic channel_six_switch,   // Channel six switch enable.
  output var  logic device_enabled        // High while the device is enabled.
);
  import pcs_pkg::*;

  // Latch and off timeouts as counter-width constants.
  localparam logic [TMR_W-1:0] LATCH_LAST = TMR_W'(LATCH_CYCLES - 1);
  localparam logic [TMR_W-1:0] OFF_LAST   = TMR_W'(OFF_CYCLES - 1);

  // Next counter value for either variant.
  function automatic logic [CH_MAX-1:0] count_next(input logic [CH_MAX-1:0] cnt,
                                                   input logic six);
    logic [CH_MAX-1:0] res;
    res = CNT_RESET;
    if (six) begin
      // The six-bit counter rolls over after sixty-four edges.
      res = cnt + 6'h01; // [RL14]
    end else begin
      // Only three bits count, so the ninth edge repeats the first.
      res = {3'h0, cnt[2:0] + 3'h1}; // [RL3]
    end
    return res;
  endfunction

  // Switch pattern for a counter value: inverse of the count minus one.
  function automatic logic [CH_MAX-1:0] decode(input logic [CH_MAX-1:0] cnt,
                                               input logic six);
    logic [CH_MAX-1:0] res;
    res = SW_RESET;
    if (six) begin
      // Sixty-four patterns over channels six down to one.
      res = ~cnt; // [RL12] [RL2]
    end else begin
      // Eight patterns over channels three down to one.
      res = {3'h0, ~cnt[2:0]}; // [RL4] [RL2]
    end
    return res;
  endfunction

  logic              sync_a;     // First synchroniser stage.
  logic              sync_b;     // Second synchroniser stage.
  logic              sync_c;     // Third synchroniser stage.
  logic              pin_level;  // Accepted pin level after filtering.
  logic              rise;       // Accepted rising edge this cycle.
  logic              fall_ok;    // Second and third stages agree.
  logic [CH_MAX-1:0] count;      // Pulse counter, holds count minus one.
  logic [CH_MAX-1:0] sw;         // Switch pattern driven onto the outputs.
  logic [TMR_W-1:0]  high_cnt;   // Cycles the pin has stayed high.
  logic              latch_done; // Pattern for this high phase is latched.
  logic [TMR_W-1:0]  low_cnt;    // Cycles the pin has stayed low.
  logic              latch_hit;  // Latch timeout reached this cycle.
  logic              off_hit;    // Off timeout reached this cycle.
  logic              wake;       // Edge that starts a fresh pulse train.

  // Three-stage synchroniser; only the second stage reads the first.
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      sync_a <= 1'b0;
      sync_b <= 1'b0;
      sync_c <= 1'b0;
    end else begin
      sync_a <= link.ctrl_pin;
      sync_b <= sync_a;
      sync_c <= sync_b;
    end
  end

  // A new level counts once the second and third stages agree.
  assign fall_ok = (sync_b == sync_c);
  // A rising edge is a change of the accepted level to high.
  assign rise = fall_ok && sync_c && !pin_level;

  // Accepted pin level, updated only when the stages agree.
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      pin_level <= 1'b0;
    end else if (fall_ok) begin
      pin_level <= sync_c;
    end
  end

  // Timeout hits, each true for one cycle as its counter reaches the end.
  assign latch_hit = device_enabled && pin_level && !latch_done && (high_cnt == LATCH_LAST);
  assign off_hit   = device_enabled && !pin_level && (low_cnt == OFF_LAST);
  // An edge in the very cycle of the off timeout still starts a fresh train,
  // so count and pattern restart instead of the switches opening while enabled.
  assign wake = rise && (!device_enabled || off_hit);

  // High-time counter, restarted by each rising edge.
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      high_cnt <= '0;
    end else if (rise || !pin_level) begin
      // A short high phase in a train restarts the count, so no midway latch.
      high_cnt <= '0; // [RL8]
    end else if (high_cnt != LATCH_LAST) begin
      high_cnt <= high_cnt + 1'b1;
    end
  end

  // Marks that the current high phase has already been latched.
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      latch_done <= 1'b0;
    end else if (rise) begin
      latch_done <= 1'b0;
    end else if (latch_hit) begin
      latch_done <= 1'b1;
    end
  end

  // Low-time counter, cleared by any high level.
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      low_cnt <= '0;
    end else if (pin_level) begin
      low_cnt <= '0;
    end else if (low_cnt != OFF_LAST) begin
      low_cnt <= low_cnt + 1'b1;
    end
  end

  // Enable state: set by the first edge, cleared by the off timeout.
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      device_enabled <= 1'b0;
    end else if (rise) begin
      // Any accepted edge at rates up to 1 MHz enables the device.
      device_enabled <= 1'b1; // [RL5] [RL9]
    end else if (off_hit) begin
      device_enabled <= 1'b0; // [RL11]
    end
  end

  // Pulse counter: cleared on enable and on disable, advanced by later edges.
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      count <= CNT_RESET;
    end else if (wake) begin
      // The first edge after disable stands for count one.
      count <= CNT_RESET; // [RL5]
    end else if (rise) begin
      count <= count_next(count, SIX_CHANNEL); // [RL1]
    end else if (off_hit) begin
      // Disable clears the count so the next edge starts afresh.
      count <= CNT_RESET; // [RL11]
    end
  end

  // Switch pattern: all on at enable, decoded count at latch, open at disable.
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      sw <= SW_RESET;
    end else if (wake) begin
      sw <= decode(CNT_RESET, SIX_CHANNEL); // [RL5]
    end else if (latch_hit) begin
      // The counted pattern takes effect only after the latch timeout.
      sw <= decode(count, SIX_CHANNEL); // [RL6]
    end else if (off_hit) begin
      sw <= SW_RESET; // [RL11]
    end
  end

  // Registered channel outputs; an on bit closes that channel's switch.
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      channel_one_switch   <= 1'b0;
      channel_two_switch   <= 1'b0;
      channel_three_switch <= 1'b0;
      channel_four_switch  <= 1'b0;
      channel_five_switch  <= 1'b0;
      channel_six_switch   <= 1'b0;
    end else begin
      channel_one_switch   <= sw[0]; // [RL10]
      channel_two_switch   <= sw[1]; // [RL10]
      channel_three_switch <= sw[2]; // [RL10]
      channel_four_switch  <= sw[3]; // [RL10]
      channel_five_switch  <= sw[4]; // [RL10]
      channel_six_switch   <= sw[5]; // [RL10]
    end
  end

endmodule
`default_nettype wire

// file: hw/pcs_pkg.sv
// Shared constants for the pulse count switch control link and both of its ends.
// Assumes one 20 MHz core clock on each end and a single host-driven control pin.
//
// What this block does
// RL1 - Each rising control edge advances the pulse counter.
// RL2 - Counter decodes to 8 or 64 channel patterns.
// RL3 - Three-channel counter wraps after eight edges.
// RL4 - Pattern is inverse of binary count minus one.
// RL5 - First edge when disabled enables, all channels on.
// RL6 - Pin held high past latch timeout latches pattern.
// RL7 - Host high phase lasts at least 50 ns.
// RL8 - Host high phase within a train under 75 us.
// RL9 - Pulse rates up to 1 MHz are counted.
// RL10 - Latched on channels assert their switch outputs.
// RL11 - Low for 500 us disables, opens, clears count.
// RL12 - Six-channel pattern is inverse of six-bit count.
// RL13 - Host low gap between 0.5 and 75 us.
// RL14 - Six-channel counter wraps after sixty-four edges.
package pcs_pkg;

  // Core clock period in nanoseconds (20 MHz).
  localparam int unsigned CLK_PERIOD_NS = 50;

  // Latch timeout in nanoseconds and its cycle count, rounded down.
  localparam int unsigned LATCH_TIMEOUT_NS = 500000;
  localparam int unsigned LATCH_CYC = LATCH_TIMEOUT_NS / CLK_PERIOD_NS;

  // Off timeout in nanoseconds and its cycle count, rounded down.
  localparam int unsigned OFF_TIMEOUT_NS = 500000;
  localparam int unsigned OFF_CYC = OFF_TIMEOUT_NS / CLK_PERIOD_NS;

  // Least high phase the device must see, rounded up.
  localparam int unsigned HIGH_MIN_NS = 50;
  localparam int unsigned HIGH_MIN_CYC = (HIGH_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Longest high or low phase inside a pulse train, rounded down.
  localparam int unsigned PHASE_MAX_NS = 75000;
  localparam int unsigned PHASE_MAX_CYC = PHASE_MAX_NS / CLK_PERIOD_NS;

  // Least low gap between counting pulses, rounded up.
  localparam int unsigned LOW_MIN_NS = 500;
  localparam int unsigned LOW_MIN_CYC = (LOW_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Host pulse phases: 500 ns high and 500 ns low give exactly 1 MHz.
  localparam int unsigned HOST_HIGH_NS = 500;
  localparam int unsigned HOST_HIGH_CYC = (HOST_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned HOST_LOW_CYC = LOW_MIN_CYC;

  // Extra cycles the host waits beyond a device timeout, covering synchroniser delay.
  localparam int unsigned HOST_MARGIN_CYC = 8;

  // Width of the timeout counters, enough for both timeouts plus margin.
  localparam int unsigned TMR_W = 16;

  // Channel pattern width and number of patterns in each variant.
  localparam int unsigned CH_MAX = 6;
  localparam int unsigned PAT_3CH = 8;
  localparam int unsigned PAT_6CH = 64;

  // Counter value after reset and after disable: first edge means count one.
  localparam logic [CH_MAX-1:0] CNT_RESET = 6'h00;

  // Switch pattern after reset and while disabled: all open.
  localparam logic [CH_MAX-1:0] SW_RESET = 6'h00;

endpackage

// file: hw/pcs_link_if.sv
// Single-wire control link between the host end and the switch device end.
// Assumes the host alone drives the pin; it is a plain one-way wire.
`timescale 1ns/1ps
`default_nettype none
interface pcs_link_if;
  // Control pin level, high while the host drives it high.
  logic ctrl_pin;
  // Device end only listens to the pin.
  modport dev (input ctrl_pin);
  // Host end drives the pin.
  modport hst (output ctrl_pin);
endinterface
`default_nettype wire

// file: hw/pcs_host.sv
// Host end: turns a requested pulse count into a train on the control pin.
// Assumes the device end samples the pin with its own core clock.
`timescale 1ns/1ps
`default_nettype none
module pcs_host #(
  parameter int unsigned LATCH_CYCLES = pcs_pkg::LATCH_CYC, // Device latch timeout.
  parameter int unsigned OFF_CYCLES   = pcs_pkg::OFF_CYC    // Device off timeout.
) (
  input  wire logic       core_clk,  // Core clock, 20 MHz.
  input  wire logic       resetn,    // Asynchronous reset, active low.
  pcs_link_if.hst         link,      // Control pin toward the device.
  input  wire logic       cmd_valid, // Request a new pattern or a shutdown.
  input  wire logic       cmd_off,   // With cmd_valid: shut the device down.
  input  wire logic [6:0] cmd_count, // Pulse count, 1 to 64.
  output var  logic       cmd_ready, // High while a request may be taken.
  output var  logic       cmd_done   // One-cycle pulse when a request completes.
);
  import pcs_pkg::*;

  // Phase lengths as counter-width constants.
  localparam logic [TMR_W-1:0] RST_LAST   = TMR_W'(OFF_CYCLES + HOST_MARGIN_CYC - 1);
  localparam logic [TMR_W-1:0] SET_LAST   = TMR_W'(LATCH_CYCLES + HOST_MARGIN_CYC - 1);
  localparam logic [TMR_W-1:0] HIGH_LAST  = TMR_W'(HOST_HIGH_CYC - 1);
  localparam logic [TMR_W-1:0] LOW_LAST   = TMR_W'(HOST_LOW_CYC - 1);

  // Host sequencer states, one-hot.
  typedef enum logic [4:0] {
    PCS_IDLE   = 5'b00001, // Waiting; pin holds its last level.
    PCS_RST    = 5'b00010, // Pin low long enough for the device to disable.
    PCS_HIGH   = 5'b00100, // High phase of a counting pulse.
    PCS_LOW    = 5'b01000, // Low gap between counting pulses.
    PCS_SETTLE = 5'b10000  // Pin held high until the device latches.
  } pcs_state_e;

  pcs_state_e       state;  // Current sequencer state.
  logic [TMR_W-1:0] tmr;    // Cycles spent in the current phase.
  logic [6:0]       left;   // Pulses still to send, including the current one.
  logic             off_op; // Current request is a shutdown.

  // Sequencer, phase timer and pin, stepped together.
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      state     <= PCS_IDLE;
      tmr       <= '0;
      left      <= 7'h00;
      off_op    <= 1'b0;
      link.ctrl_pin <= 1'b0;
      cmd_ready <= 1'b1;
      cmd_done  <= 1'b0;
    end else begin
      cmd_done <= 1'b0;
      tmr      <= tmr + 1'b1;
      case (state)
        PCS_IDLE: begin
          if (cmd_valid) begin
            // Every request starts by disabling so the count starts afresh.
            state         <= PCS_RST;
            tmr           <= '0;
            off_op        <= cmd_off;
            left          <= (cmd_count == 7'h00) ? 7'h01 : cmd_count;
            link.ctrl_pin <= 1'b0;
            cmd_ready     <= 1'b0;
          end
        end
        PCS_RST: begin
          if (tmr == RST_LAST) begin
            tmr <= '0;
            if (off_op) begin
              state     <= PCS_IDLE;
              cmd_ready <= 1'b1;
              cmd_done  <= 1'b1;
            end else begin
              state         <= PCS_HIGH;
              link.ctrl_pin <= 1'b1;
            end
          end
        end
        PCS_HIGH: begin
          // High phase of 500 ns: above 50 ns, below 75 us, 1 MHz rate.
          if (tmr == HIGH_LAST) begin // [RL7] [RL8] [RL9]
            tmr  <= '0;
            left <= left - 7'h01;
            if (left == 7'h01) begin
              state <= PCS_SETTLE;
            end else begin
              state         <= PCS_LOW;
              link.ctrl_pin <= 1'b0;
            end
          end
        end
        PCS_LOW: begin
          // Low gap of 500 ns, inside the 0.5 to 75 us window.
          if (tmr == LOW_LAST) begin // [RL13]
            tmr           <= '0;
            state         <= PCS_HIGH;
            link.ctrl_pin <= 1'b1;
          end
        end
        PCS_SETTLE: begin
          // Pin stays high past the latch timeout, and afterwards.
          if (tmr == SET_LAST) begin // [RL6]
            state     <= PCS_IDLE;
            cmd_ready <= 1'b1;
            cmd_done  <= 1'b1;
          end
        end
        default: begin
          state         <= PCS_IDLE;
          link.ctrl_pin <= 1'b0;
          cmd_ready     <= 1'b1;
        end
      endcase
    end
  end

endmodule
`default_nettype wire

// file: testbench/pcs_link_chk.sv
// Checker for the link between the host end and the three-channel device end.
// Assumes one core clock and that it watches the pin and device outputs directly.
`timescale 1ns/1ps
`default_nettype none
module pcs_link_chk #(
  parameter int unsigned LATCH_CYCLES = pcs_pkg::LATCH_CYC, // Device latch timeout in cycles.
  parameter int unsigned OFF_CYCLES   = pcs_pkg::OFF_CYC    // Device off timeout in cycles.
) (
  input wire logic core_clk,             // Core clock.
  input wire logic resetn,               // Asynchronous reset, active low.
  input wire logic ctrl_pin,             // Control pin level.
  input wire logic channel_one_switch,   // Channel one enable.
  input wire logic channel_two_switch,   // Channel two enable.
  input wire logic channel_three_switch, // Channel three enable.
  input wire logic channel_four_switch,  // Channel four enable.
  input wire logic channel_five_switch,  // Channel five enable.
  input wire logic channel_six_switch,   // Channel six enable.
  input wire logic device_enabled        // Device enabled flag.
);
  logic [15:0] high_cnt; // Cycles the pin has stayed high, saturating.
  logic [15:0] low_cnt;  // Cycles the pin has stayed low, saturating.
  logic [2:0]  sw;       // The three channel outputs, channel three first.
  assign sw = {channel_three_switch, channel_two_switch, channel_one_switch};
  // Measures how long the pin has held its present level.
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      high_cnt <= 16'h0000;
      low_cnt  <= 16'h0000;
    end else begin
      high_cnt <= !ctrl_pin ? 16'h0000 : high_cnt + {15'h0000, high_cnt != 16'hFFFF};
      low_cnt  <= ctrl_pin ? 16'h0000 : low_cnt + {15'h0000, low_cnt != 16'hFFFF};
    end
  end
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!resetn);
  AST_OFF_OPENS: assert property ($fell(device_enabled) |=> sw == 3'h0)
    else $error("switches not opened after disable");
  AST_OFF_WAITS: assert property ($fell(device_enabled) |-> low_cnt >= OFF_CYCLES)
    else $error("device disabled before the off timeout");
  AST_OFF_BOUND: assert property (low_cnt > OFF_CYCLES + 8 |-> !device_enabled && sw == 3'h0)
    else $error("device still enabled long after pin went low");
  AST_ON_ALL: assert property ($rose(device_enabled) |=> sw == 3'h7)
    else $error("first edge did not turn every channel on");
  AST_ON_CAUSE: assert property ($rose(device_enabled) |-> $past(ctrl_pin, 3))
    else $error("device enabled without a rising pin");
  AST_ON_BOUND: assert property (high_cnt == 16'h0008 |-> device_enabled)
    else $error("device not enabled while the pin is high");
  AST_LATCH_WAIT: assert property ($changed(sw) && device_enabled && $past(device_enabled, 2)
    |-> high_cnt >= LATCH_CYCLES)
    else $error("pattern changed before the latch timeout");
  AST_LATCH_ONCE: assert property (high_cnt > LATCH_CYCLES + 8 |-> $stable(sw))
    else $error("pattern changed twice in one high phase");
  AST_THREE_ONLY: assert property ({channel_six_switch, channel_five_switch,
    channel_four_switch} == 3'h0)
    else $error("upper channels driven in the three-channel variant");
  COV_ENABLE: cover property ($rose(device_enabled));
  COV_DISABLE: cover property ($fell(device_enabled));
  COV_LATCHED: cover property (high_cnt == LATCH_CYCLES + 9 && sw != 3'h7);
endmodule
`default_nettype wire

// file: testbench/tb.sv
// Testbench: host end drives a three-channel device; the bench drives a six-channel one.
// Assumes the package timeouts are shortened to 40 cycles through parameters.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import pcs_pkg::*;
  localparam int unsigned LAT = 40; // Shortened latch timeout in cycles.
  localparam int unsigned OFF = 40; // Shortened off timeout in cycles.
  logic            core_clk;        // Core clock.
  logic            resetn;          // Reset, active low.
  logic            cmd_valid;       // Host request.
  logic            cmd_off;         // Host shutdown request.
  logic      [6:0] cmd_count;       // Host pulse count.
  wire logic       cmd_ready;       // Host ready.
  wire logic       cmd_done;        // Host completion pulse.
  wire logic [5:0] sw_a;            // Three-channel device outputs, channel one at bit 0.
  wire logic [5:0] sw_b;            // Six-channel device outputs, channel one at bit 0.
  wire logic       en_a;            // Three-channel device enabled.
  wire logic       en_b;            // Six-channel device enabled.
  int              mismatches;      // Failed comparisons.
  int              samples_checked; // All comparisons.
  pcs_link_if lnk ();
  pcs_link_if lnk6 ();
  pcs_host #(.LATCH_CYCLES(LAT), .OFF_CYCLES(OFF)) pcs_host_inst (.core_clk(core_clk),
    .resetn(resetn), .link(lnk.hst), .cmd_valid(cmd_valid), .cmd_off(cmd_off),
    .cmd_count(cmd_count), .cmd_ready(cmd_ready), .cmd_done(cmd_done));
  pcs_device #(.SIX_CHANNEL(1'b0), .LATCH_CYCLES(LAT), .OFF_CYCLES(OFF)) pcs_device_inst (
    .core_clk(core_clk), .resetn(resetn), .link(lnk.dev), .channel_one_switch(sw_a[0]),
    .channel_two_switch(sw_a[1]), .channel_three_switch(sw_a[2]), .channel_four_switch(sw_a[3]),
    .channel_five_switch(sw_a[4]), .channel_six_switch(sw_a[5]), .device_enabled(en_a));
  pcs_device #(.SIX_CHANNEL(1'b1), .LATCH_CYCLES(LAT), .OFF_CYCLES(OFF)) pcs_device_inst2 (
    .core_clk(core_clk), .resetn(resetn), .link(lnk6.dev), .channel_one_switch(sw_b[0]),
    .channel_two_switch(sw_b[1]), .channel_three_switch(sw_b[2]), .channel_four_switch(sw_b[3]),
    .channel_five_switch(sw_b[4]), .channel_six_switch(sw_b[5]), .device_enabled(en_b));
  pcs_link_chk #(.LATCH_CYCLES(LAT), .OFF_CYCLES(OFF)) pcs_link_chk_inst (.core_clk(core_clk),
    .resetn(resetn), .ctrl_pin(lnk.ctrl_pin), .channel_one_switch(sw_a[0]),
    .channel_two_switch(sw_a[1]), .channel_three_switch(sw_a[2]), .channel_four_switch(sw_a[3]),
    .channel_five_switch(sw_a[4]), .channel_six_switch(sw_a[5]), .device_enabled(en_a));
  // Clock of 50 ns period.
  initial core_clk = 1'b0;
  always #25 core_clk = ~core_clk;
  // Compares a switch pattern.
  task automatic check_vec(input logic [5:0] got, input logic [5:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR t=%0t switches %h expected %h", $time, got, exp);
    end
  endtask
  // Compares a single flag.
  task automatic check_bit(input logic got, input logic exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR t=%0t flag %b expected %b", $time, got, exp);
    end
  endtask
  // Expected pattern: inverse of count minus one, wrapped to the variant's pattern count.
  function automatic logic [5:0] exp_pat(input int n, input int pats);
    int v;
    v = (n - 1) % pats;
    return ~v[5:0] & 6'(pats - 1);
  endfunction
  // Sends one host request and waits a bounded time for its completion.
  task automatic host_req(input logic off, input int n);
    int k;
    @(negedge core_clk);
    cmd_valid = 1'b1;
    cmd_off = off;
    cmd_count = 7'(n);
    @(negedge core_clk);
    cmd_valid = 1'b0;
    check_bit(cmd_ready, 1'b0);
    k = 0;
    while (cmd_done !== 1'b1 && k < 4000) begin
      @(negedge core_clk);
      k++;
    end
    if (k == 4000) begin
      mismatches++;
      $display("ERROR t=%0t host request never completed", $time);
    end
    check_bit(cmd_ready, 1'b1);
    @(negedge core_clk);
  endtask
  // Drives a 1 MHz train on the second pin; pulse two may be stretched on purpose.
  task automatic drive6(input int n, input int hold2);
    lnk6.ctrl_pin = 1'b0;
    repeat (OFF + 8) @(negedge core_clk);
    for (int i = 1; i <= n; i++) begin
      lnk6.ctrl_pin = 1'b1;
      repeat ((i == 2) ? hold2 : 10) @(negedge core_clk);
      if (i == 2 && hold2 > 10) check_vec(sw_b, exp_pat(2, 64));
      if (i < n) begin
        lnk6.ctrl_pin = 1'b0;
        repeat (10) @(negedge core_clk);
      end
    end
    repeat (LAT + 8) @(negedge core_clk);
  endtask
  // Prints the counts and the verdict, then ends the run.
  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // Cuts a hang short.
  initial begin
    repeat (60000) @(posedge core_clk);
    mismatches++;
    $display("ERROR t=%0t watchdog expired", $time);
    print_verdict();
  end
  // Main sequence.
  initial begin
    int n;
    int six_counts[6];
    six_counts = '{1, 2, 33, 64, 65, 0};
    cmd_valid = 1'b0;
    cmd_off = 1'b0;
    cmd_count = 7'h01;
    lnk6.ctrl_pin = 1'b0;
    mismatches = 0;
    samples_checked = 0;
    resetn = 1'b0;
    void'($urandom(32'h17BE6D5C));
    repeat (8) @(negedge core_clk);
    check_vec(sw_a, 6'h00);
    check_bit(en_a, 1'b0);
    resetn = 1'b1;
    // Counts one to nine cover every pattern and the wrap; then a corner and random counts.
    for (int i = 1; i <= 14; i++) begin
      n = (i <= 9) ? i : ((i == 10) ? 16 : 1 + int'($urandom % 64));
      host_req(1'b0, n);
      check_vec(sw_a, exp_pat(n, 8));
      check_bit(en_a, 1'b1);
    end
    host_req(1'b1, 0);
    check_bit(en_a, 1'b0);
    check_vec(sw_a, 6'h00);
    // Six-channel patterns, including the wrap after sixty-four edges.
    for (int i = 0; i < 6; i++) begin
      n = (six_counts[i] == 0) ? 1 + int'($urandom % 64) : six_counts[i];
      drive6(n, 10);
      check_vec(sw_b, exp_pat(n, 64));
      check_bit(en_b, 1'b1);
    end
    drive6(3, LAT + 8);
    check_vec(sw_b, exp_pat(3, 64));
    lnk6.ctrl_pin = 1'b0;
    repeat (OFF + 8) @(negedge core_clk);
    check_vec(sw_b, 6'h00);
    check_bit(en_b, 1'b0);
    print_verdict();
  end
endmodule
`default_nettype wire
